// ===== design/rtc_ctrl_pkg.sv
// package for the real-time clock control block: offsets, bit positions, resets, timing
// assumes a single 100 MHz register clock; no imports anywhere
package rtc_ctrl_pkg;

   localparam logic [7:0] OFS_CLOCK_TIMER_CONTROL    = 8'h04;
   localparam logic [7:0] OFS_OSCILLATOR_CONTROL     = 8'h05;
   localparam logic [7:0] OFS_OSCILLATOR_LOAD_CONFIG = 8'h06;
   localparam logic [7:0] OFS_HOLD0                  = 8'h00;
   localparam logic [7:0] OFS_ALARM0                 = 8'h08;

   // clock_timer_control bits
   localparam int B_OSC_ENABLE   = 7;
   localparam int B_MCD_ENABLE   = 6;
   localparam int B_OSC_FAIL     = 5;
   localparam int B_TIMER_RUN    = 4;
   localparam int B_ALARM_ENABLE = 3;
   localparam int B_ALARM_AUTO   = 2;
   localparam int B_SET_CMD      = 1;
   localparam int B_CAPTURE_CMD  = 0;
   // oscillator_control bits
   localparam int B_GAIN_CTRL    = 7;
   localparam int B_XTAL_MODE    = 6;
   localparam int B_BIAS_DOUBLE  = 5;
   localparam int B_XTAL_VALID   = 4;
   // oscillator_load_config bits
   localparam int B_AUTO_STEP    = 7;
   localparam int B_LOAD_READY   = 6;
   localparam int B_LOAD_LSB     = 0;
   localparam int LOAD_W         = 4;

   localparam logic [7:0] RST_CLOCK_TIMER_CONTROL = 8'h00;
   localparam logic [7:0] RST_OSCILLATOR_CONTROL  = 8'h00;
   localparam logic [7:0] RST_LOAD_CONFIG         = 8'h00;

   // missing clock timeout: more than 100 us without an edge
   localparam int CLK_PERIOD_NS  = 10;
   localparam int MCD_TIMEOUT_US = 100;
   localparam int MCD_CYCLES     = (MCD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed
   {
      logic       osc_power;
      logic       gain_ctrl;
      logic       xtal_mode;
      logic       bias_double;
      logic [3:0] load_cap;
   } osc_ctl_t;

endpackage : rtc_ctrl_pkg

// ===== design/rtc_cap_stepper.sv
// load capacitance stepper: walks the applied setting one step per tick toward target
// assumes tick is a one-cycle strobe in the register clock domain
module rtc_cap_stepper #(
   parameter int W = 4
) (
   input  wire logic         MCLK,
   input  wire logic         RSTN,
   input  wire logic         CE,
   input  wire logic         STEP_EN,
   input  wire logic         TICK,
   input  wire logic [W-1:0] TARGET,
   output logic      [W-1:0] APPLIED,
   output logic              READY
);

   logic [W-1:0] cur_ff;
   logic [W-1:0] nxt_cur;
   logic         ready_ff;
   wire          at_target = (cur_ff == TARGET);
   wire          go_up     = (cur_ff < TARGET);

   // stepping only when enabled; otherwise the setting holds where it is
   assign nxt_cur = (!STEP_EN || !TICK || at_target) ? cur_ff :
                    go_up ? W'(cur_ff + 1'b1) : W'(cur_ff - 1'b1);

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         cur_ff   <= '0;
         ready_ff <= 1'b0;
      end
      else if (CE)
      begin
         cur_ff   <= nxt_cur;
         ready_ff <= (nxt_cur == TARGET);
      end
   end

   assign APPLIED = cur_ff;
   assign READY   = ready_ff;

endmodule : rtc_cap_stepper

// ===== design/rtc_ctrl.sv
// real-time clock control: control registers, 32-bit timer, alarm, missing clock detect
// assumes a byte register port synchronous to MCLK, oscillator output sampled as data
//
// Operation
// - oscillator and bias power follow the oscillator enable bit 7.
// - missing clock detector works only while bit 6 is set.
// - oscillator stuck high or low beyond 100 us raises fail event.
// - fail flag bit 5 is set by hardware, cleared by host write.
// - timer advances while run bit 4 is one, else holds.
// - running timer increments once per slow oscillator cycle.
// - alarm enable bit 3 gates alarms; writing it clears alarm flag.
// - bit 2 reads alarm flag, writes auto reset enable.
// - alarm flag stays set until the next oscillator tick without a match.
// - writing set bit 1 loads timer; hardware clears bit when done.
// - writing capture bit 0 snapshots timer; hardware clears bit when done.
// - set copies holding bytes to timer; capture copies timer to bytes.
// - oscillator control bit 7 switches automatic gain control.
// - oscillator control bit 6 selects crystal (1) or self-oscillate (0).
// - oscillator control bit 5 enables bias doubling.
// - oscillator control bit 4 is read-only crystal valid.
// - unused bits read zero and ignore writes.
// - load config bit 7 enables automatic capacitance stepping.
// - load config bit 6 reads one once capacitance reaches target.
// - load config bits 3:0 hold the stepping target.
module rtc_ctrl #(
   parameter int MCD_LIMIT = rtc_ctrl_pkg::MCD_CYCLES
) (
   input  wire logic                     MCLK,
   input  wire logic                     RSTN,
   input  wire logic                     CE,
   input  wire rtc_ctrl_pkg::reg_req_t   REQ,
   input  wire logic                     OSC_IN,
   input  wire logic                     XTAL_AMP_OK,
   output logic [7:0]                    RDATA,
   output logic                          RVALID,
   output rtc_ctrl_pkg::osc_ctl_t        OSC_CTL,
   output logic                          OSC_FAIL_EVENT,
   output logic                          ALARM_EVENT,
   output logic [31:0]                   TIMER
);

   logic [7:0]  ctl_ff;
   logic [7:0]  oscc_ff;
   logic [7:0]  loadc_ff;
   logic [31:0] hold_ff;
   logic [31:0] alarm_ff;
   logic [31:0] timer_ff;
   logic [31:0] nxt_timer;
   logic        alarm_flag_ff;
   logic        auto_reset_ff;
   logic        clear_pend_ff;
   logic [2:0]  osc_sync_ff;
   logic [16:0] stuck_ff;
   logic        fail_evt_ff;
   logic        alarm_evt_ff;
   logic [7:0]  rdata_ff;
   logic        rvalid_ff;
   logic        xv_ff;
   logic [3:0]  cap_applied;
   logic        cap_ready;

   wire wr_ctl   = REQ.wr && (REQ.addr == rtc_ctrl_pkg::OFS_CLOCK_TIMER_CONTROL);
   wire wr_oscc  = REQ.wr && (REQ.addr == rtc_ctrl_pkg::OFS_OSCILLATOR_CONTROL);
   wire wr_loadc = REQ.wr && (REQ.addr == rtc_ctrl_pkg::OFS_OSCILLATOR_LOAD_CONFIG);
   wire wr_hold  = REQ.wr && (REQ.addr[7:2] == rtc_ctrl_pkg::OFS_HOLD0[7:2]);
   wire wr_alarm = REQ.wr && (REQ.addr[7:2] == rtc_ctrl_pkg::OFS_ALARM0[7:2]);

   // osc_sync_ff[0] feeds only [1]; edge detect looks at [1] and [2]
   wire osc_edge = osc_sync_ff[2] ^ osc_sync_ff[1];
   wire osc_tick = ctl_ff[rtc_ctrl_pkg::B_OSC_ENABLE] && osc_edge && osc_sync_ff[1];
   wire mcd_on   = ctl_ff[rtc_ctrl_pkg::B_MCD_ENABLE] && ctl_ff[rtc_ctrl_pkg::B_OSC_ENABLE];
   wire stuck_to = mcd_on && (32'(stuck_ff) >= MCD_LIMIT);
   wire alarm_hit = osc_tick && ctl_ff[rtc_ctrl_pkg::B_ALARM_ENABLE] &&
                    (timer_ff == alarm_ff);

   // set/capture act on an oscillator tick, so they are ordered with counting
   wire do_set = osc_tick && ctl_ff[rtc_ctrl_pkg::B_SET_CMD];
   wire do_cap = osc_tick && ctl_ff[rtc_ctrl_pkg::B_CAPTURE_CMD];

   function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] idx);
      byte_of = w[8*idx +: 8];
   endfunction : byte_of

   always_comb
   begin
      nxt_timer = timer_ff;
      if (osc_tick)
      begin
         if (do_set)
            nxt_timer = hold_ff;
         else if (clear_pend_ff)
            nxt_timer = '0;
         else if (ctl_ff[rtc_ctrl_pkg::B_TIMER_RUN])
            nxt_timer = timer_ff + 32'h0000_0001;
      end
   end

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         osc_sync_ff <= 3'h0;
         stuck_ff    <= 17'h00000;
         fail_evt_ff <= 1'b0;
      end
      else if (CE)
      begin
         osc_sync_ff <= {osc_sync_ff[1:0], OSC_IN};
         // counter saturates; a new edge or disable restarts it
         if (!mcd_on || osc_edge)
            stuck_ff <= 17'h00000;
         else if (!stuck_to)
            stuck_ff <= 17'(stuck_ff + 1'b1);
         // fire on the step into the limit only; the counter then sits saturated
         fail_evt_ff <= mcd_on && !osc_edge && (32'(stuck_ff) == MCD_LIMIT - 1);
      end
   end

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ctl_ff        <= rtc_ctrl_pkg::RST_CLOCK_TIMER_CONTROL;
         auto_reset_ff <= 1'b0;
      end
      else if (CE)
      begin
         if (wr_ctl)
         begin
            ctl_ff[7:6]   <= REQ.wdata[7:6];
            ctl_ff[4:3]   <= REQ.wdata[4:3];
            auto_reset_ff <= REQ.wdata[rtc_ctrl_pkg::B_ALARM_AUTO];
         end
         // fail flag: hardware set wins over a host clear in the same cycle
         if (stuck_to)
            ctl_ff[rtc_ctrl_pkg::B_OSC_FAIL] <= 1'b1;
         else if (wr_ctl)
            ctl_ff[rtc_ctrl_pkg::B_OSC_FAIL] <= REQ.wdata[rtc_ctrl_pkg::B_OSC_FAIL];
         // command bits: writing 1 starts, completion clears; writing 0 is ignored
         if (do_set)
            ctl_ff[rtc_ctrl_pkg::B_SET_CMD] <= 1'b0;
         else if (wr_ctl && REQ.wdata[rtc_ctrl_pkg::B_SET_CMD])
            ctl_ff[rtc_ctrl_pkg::B_SET_CMD] <= 1'b1;
         if (do_cap)
            ctl_ff[rtc_ctrl_pkg::B_CAPTURE_CMD] <= 1'b0;
         else if (wr_ctl && REQ.wdata[rtc_ctrl_pkg::B_CAPTURE_CMD])
            ctl_ff[rtc_ctrl_pkg::B_CAPTURE_CMD] <= 1'b1;
         ctl_ff[rtc_ctrl_pkg::B_ALARM_AUTO] <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         timer_ff      <= 32'h0000_0000;
         hold_ff       <= 32'h0000_0000;
         alarm_ff      <= 32'h0000_0000;
         alarm_flag_ff <= 1'b0;
         alarm_evt_ff  <= 1'b0;
         clear_pend_ff <= 1'b0;
      end
      else if (CE)
      begin
         timer_ff <= nxt_timer;
         if (do_cap)
            hold_ff <= timer_ff;
         else if (wr_hold)
            hold_ff[8*REQ.addr[1:0] +: 8] <= REQ.wdata;
         if (wr_alarm)
            alarm_ff[8*REQ.addr[1:0] +: 8] <= REQ.wdata;
         if (osc_tick)
            clear_pend_ff <= alarm_hit && auto_reset_ff;
         // flag lives until a tick without a match; writing the control register clears it
         if (alarm_hit)
            alarm_flag_ff <= 1'b1;
         else if (osc_tick || wr_ctl)
            alarm_flag_ff <= 1'b0;
         alarm_evt_ff <= alarm_hit;
      end
   end

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         oscc_ff  <= rtc_ctrl_pkg::RST_OSCILLATOR_CONTROL;
         loadc_ff <= rtc_ctrl_pkg::RST_LOAD_CONFIG;
         xv_ff    <= 1'b0;
      end
      else if (CE)
      begin
         if (wr_oscc)
            oscc_ff <= {REQ.wdata[7:5], 5'h00};
         if (wr_loadc)
            loadc_ff <= {REQ.wdata[7], 3'h0, REQ.wdata[3:0]};
         xv_ff <= XTAL_AMP_OK && ctl_ff[rtc_ctrl_pkg::B_OSC_ENABLE];
      end
   end

   // stepping runs on oscillator ticks so the analog load sees a slow ramp
   rtc_cap_stepper #(
      .W (rtc_ctrl_pkg::LOAD_W)
   ) u_stepper (
      .MCLK    (MCLK),
      .RSTN    (RSTN),
      .CE      (CE),
      .STEP_EN (loadc_ff[rtc_ctrl_pkg::B_AUTO_STEP]),
      .TICK    (osc_tick),
      .TARGET  (loadc_ff[3:0]),
      .APPLIED (cap_applied),
      .READY   (cap_ready)
   );

   wire [7:0] rd_ctl   = {ctl_ff[7:3], alarm_flag_ff, ctl_ff[1:0]};
   wire [7:0] rd_oscc  = {oscc_ff[7:5], xv_ff, 4'h0};
   wire [7:0] rd_loadc = {loadc_ff[7], cap_ready, 2'h0, loadc_ff[3:0]};
   wire [7:0] rd_mux   =
      (REQ.addr == rtc_ctrl_pkg::OFS_CLOCK_TIMER_CONTROL)    ? rd_ctl   :
      (REQ.addr == rtc_ctrl_pkg::OFS_OSCILLATOR_CONTROL)     ? rd_oscc  :
      (REQ.addr == rtc_ctrl_pkg::OFS_OSCILLATOR_LOAD_CONFIG) ? rd_loadc :
      (REQ.addr[7:2] == rtc_ctrl_pkg::OFS_HOLD0[7:2])        ? byte_of(hold_ff, REQ.addr[1:0]) :
      (REQ.addr[7:2] == rtc_ctrl_pkg::OFS_ALARM0[7:2])       ? byte_of(alarm_ff, REQ.addr[1:0]) :
      8'h00;

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
      end
      else if (CE)
      begin
         rvalid_ff <= REQ.rd;
         if (REQ.rd)
            rdata_ff <= rd_mux;
      end
   end

   logic [7:0] osc_out_ff;
   wire [6:0]  nxt_osc_bits = {oscc_ff[7:5], cap_applied};

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         osc_out_ff <= 8'h00;
      else if (CE)
         osc_out_ff <= {ctl_ff[rtc_ctrl_pkg::B_OSC_ENABLE], nxt_osc_bits};
   end

   assign OSC_CTL        = osc_out_ff;
   assign OSC_FAIL_EVENT = fail_evt_ff;
   assign ALARM_EVENT    = alarm_evt_ff;
   assign TIMER          = timer_ff;
   assign RDATA          = rdata_ff;
   assign RVALID         = rvalid_ff;

   property p_fail_set;
      @(posedge MCLK) disable iff (!RSTN) (CE && stuck_to) |=> ctl_ff[rtc_ctrl_pkg::B_OSC_FAIL];
   endproperty
   a_fail_set: assert property (p_fail_set) else $error("fail flag not set");

   property p_fail_pulse;
      @(posedge MCLK) disable iff (!RSTN) (CE && fail_evt_ff) |=> !fail_evt_ff;
   endproperty
   a_fail_pulse: assert property (p_fail_pulse) else $error("fail event longer than one cycle");

   property p_mcd_off;
      @(posedge MCLK) disable iff (!RSTN) (CE && !mcd_on) |=> (stuck_ff == 17'h00000);
   endproperty
   a_mcd_off: assert property (p_mcd_off) else $error("detector active while off");

   property p_hold;
      @(posedge MCLK) disable iff (!RSTN)
         (CE && !ctl_ff[4] && !do_set && !clear_pend_ff) |=> $stable(timer_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("timer moved while stopped");

   property p_count;
      @(posedge MCLK) disable iff (!RSTN)
         (CE && osc_tick && ctl_ff[4] && !do_set && !clear_pend_ff)
         |=> timer_ff == $past(timer_ff) + 32'h0000_0001;
   endproperty
   a_count: assert property (p_count) else $error("timer did not step");

   property p_autoreset;
      @(posedge MCLK) disable iff (!RSTN)
         (CE && alarm_hit && auto_reset_ff && !do_set) |=> clear_pend_ff;
   endproperty
   a_autoreset: assert property (p_autoreset) else $error("auto reset not armed");

   property p_alarm_flag;
      @(posedge MCLK) disable iff (!RSTN) (CE && alarm_hit) |=> alarm_flag_ff;
   endproperty
   a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag missing");

   property p_set_done;
      @(posedge MCLK) disable iff (!RSTN) (CE && do_set) |=> (timer_ff == $past(hold_ff))
         && !ctl_ff[rtc_ctrl_pkg::B_SET_CMD];
   endproperty
   a_set_done: assert property (p_set_done) else $error("set did not load");

   property p_cap_done;
      @(posedge MCLK) disable iff (!RSTN) (CE && do_cap) |=> (hold_ff == $past(timer_ff))
         && !ctl_ff[rtc_ctrl_pkg::B_CAPTURE_CMD];
   endproperty
   a_cap_done: assert property (p_cap_done) else $error("capture did not store");

   c_alarm: cover property (@(posedge MCLK) disable iff (!RSTN) alarm_hit);
   c_fail:  cover property (@(posedge MCLK) disable iff (!RSTN) fail_evt_ff);
   c_cap:   cover property (@(posedge MCLK) disable iff (!RSTN) do_cap);

endmodule : rtc_ctrl

// ===== sim/rtc_host_model.sv
// host model: byte register requests and command polling on the register port
// assumes the bench calls its tasks; requests change on the falling edge
module rtc_host_model (
   input  wire logic                   MCLK,
   input  wire logic [7:0]             RDATA,
   input  wire logic                   RVALID,
   output rtc_ctrl_pkg::reg_req_t      REQ
);
   timeunit 1ns;
   timeprecision 1ps;
   initial REQ = '0;
   // released lines show the inverse of the last value, so nothing stale looks valid
   task automatic drop();
      REQ = '{wr: 1'b0, rd: 1'b0, addr: ~REQ.addr, wdata: ~REQ.wdata};
   endtask : drop
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge MCLK);
      REQ = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge MCLK);
      drop();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge MCLK);
      REQ = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge MCLK);
      drop();
      d = 8'hXX;
      for (int i = 0; i < 3; i++)
      begin
         if (RVALID === 1'b1)
         begin
            d = RDATA;
            break;
         end
         @(negedge MCLK);
      end
   endtask : rd
   task automatic poll(input logic [7:0] a, input int b, input logic v, output logic ok);
      logic [7:0] d;
      ok = 1'b0;
      for (int i = 0; i < 60 && !ok; i++)
      begin
         rd(a, d);
         ok = (d[b] === v);
      end
   endtask : poll
endmodule : rtc_host_model

// ===== sim/tb.sv
// self-checking bench for the real-time clock control block
// assumes the host model above; oscillator made here with a 10-cycle period
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MCD_LIM = 50;
   localparam logic [7:0] A_CTL = rtc_ctrl_pkg::OFS_CLOCK_TIMER_CONTROL;
   localparam logic [7:0] A_OSC = rtc_ctrl_pkg::OFS_OSCILLATOR_CONTROL;
   localparam logic [7:0] A_LD  = rtc_ctrl_pkg::OFS_OSCILLATOR_LOAD_CONFIG;
   logic                   mclk    = 1'b0;
   logic                   rstn    = 1'b0;
   logic                   osc_in  = 1'b0;
   logic                   amp_ok  = 1'b0;
   logic                   osc_run = 1'b1;
   logic                   ce      = 1'b1;
   rtc_ctrl_pkg::reg_req_t req;
   rtc_ctrl_pkg::osc_ctl_t osc_ctl;
   logic [7:0]             rdata;
   logic [7:0]             d;
   logic                   rvalid;
   logic                   fail_ev;
   logic                   alarm_ev;
   logic                   ok;
   logic [31:0]            timer;
   logic [31:0]            t0;
   int                     error_cnt = 0;
   int                     n_checks  = 0;
   int                     cyc       = 0;
   int                     div       = 0;
   int                     n;

   rtc_ctrl #(.MCD_LIMIT(MCD_LIM)) rtc_ctrl_i (.MCLK(mclk), .RSTN(rstn), .CE(ce),
      .REQ(req), .OSC_IN(osc_in), .XTAL_AMP_OK(amp_ok), .RDATA(rdata), .RVALID(rvalid),
      .OSC_CTL(osc_ctl), .OSC_FAIL_EVENT(fail_ev), .ALARM_EVENT(alarm_ev), .TIMER(timer));
   rtc_host_model rtc_host_model_i (.MCLK(mclk), .RDATA(rdata), .RVALID(rvalid), .REQ(req));

   always #5 mclk = ~mclk;

   // stopping the divider freezes the oscillator level, as a dead crystal would
   always @(negedge mclk)
   begin
      if (osc_run)
      begin
         div <= (div == 4) ? 0 : div + 1;
         if (div == 4)
            osc_in <= ~osc_in;
      end
   end

   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk32
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rtc_host_model_i.rd(a, v);
      chk8($sformatf("reg %h", a), e, v);
   endtask : rdchk
   task automatic put4(input logic [7:0] base, input logic [31:0] v);
      for (int i = 0; i < 4; i++)
         rtc_host_model_i.wr(base + 8'(i), v[8*i+:8]);
   endtask : put4
   task automatic cmd(input logic [7:0] v, input int b);
      rtc_host_model_i.wr(A_CTL, v);
      rtc_host_model_i.poll(A_CTL, b, 1'b0, ok);
      chk8("command done", 8'h01, {7'h00, ok});
   endtask : cmd
   // returns lim when the chosen event never showed
   task automatic wait_hi(input int lim, input bit on_fail, output int n);
      n = 0;
      while (n < lim && ((on_fail ? fail_ev : alarm_ev) !== 1'b1))
      begin
         @(negedge mclk);
         n++;
      end
   endtask : wait_hi

   initial
   begin
      repeat (12) @(negedge mclk);
      rstn = 1'b1;
      rdchk(A_CTL, rtc_ctrl_pkg::RST_CLOCK_TIMER_CONTROL);
      rdchk(A_OSC, rtc_ctrl_pkg::RST_OSCILLATOR_CONTROL);
      rdchk(8'h20, 8'h00);
      chk8("osc ctl", 8'h00, osc_ctl);
      rtc_host_model_i.wr(A_CTL, 8'h80);
      // the pin image is registered once more behind the control register
      @(negedge mclk);
      chk8("osc ctl", 8'h80, osc_ctl);
      rtc_host_model_i.wr(A_OSC, 8'hFF);
      rdchk(A_OSC, 8'hE0);
      chk8("osc ctl", 8'hF0, osc_ctl);
      amp_ok = 1'b1;
      rdchk(A_OSC, 8'hF0);
      rtc_host_model_i.wr(A_OSC, 8'h40);
      rdchk(A_OSC, 8'h50);
      chk8("osc ctl", 8'hA0, osc_ctl);
      put4(8'h00, 32'h89AB_CDEF);
      cmd(8'h82, 1);
      chk32("timer set", 32'h89AB_CDEF, timer);
      repeat (40) @(negedge mclk);
      chk32("timer held", 32'h89AB_CDEF, timer);
      put4(8'h00, 32'h0000_0000);
      cmd(8'h81, 0);
      for (int i = 0; i < 4; i++)
      begin
         rtc_host_model_i.rd(8'(i), d);
         t0[8*i+:8] = d;
      end
      chk32("capture", 32'h89AB_CDEF, t0);
      rtc_host_model_i.wr(A_CTL, 8'h90);
      repeat (20) @(negedge mclk);
      t0 = timer;
      repeat (70) @(negedge mclk);
      chk32("timer rate", t0 + 32'h7, timer);
      ce = 1'b0;
      t0 = timer;
      repeat (30) @(negedge mclk);
      chk32("ce freeze", t0, timer);
      ce = 1'b1;
      put4(8'h08, 32'h0000_0005);
      put4(8'h00, 32'h0000_0000);
      cmd(8'h92, 1);
      rtc_host_model_i.wr(A_CTL, 8'h9C);
      wait_hi(200, 1'b0, n);
      // the event lags the match tick, by which the timer has stepped once more
      chk32("alarm at match", 32'h6, timer);
      @(negedge mclk);
      chk8("alarm pulse", 8'h00, {7'h00, alarm_ev});
      rdchk(A_CTL, 8'h9C);
      repeat (9) @(negedge mclk);
      chk32("auto reset", 32'h0, timer);
      rdchk(A_CTL, 8'h98);
      rtc_host_model_i.wr(A_CTL, 8'h94);
      wait_hi(200, 1'b0, n);
      chk32("alarm off", 200, n);
      osc_run = 1'b0;
      rtc_host_model_i.wr(A_CTL, 8'hC0);
      wait_hi(120, 1'b1, n);
      chk8("fail delay", 8'h01, {7'h00, n >= MCD_LIM - 3 && n <= MCD_LIM + 6});
      rdchk(A_CTL, 8'hE0);
      osc_run = 1'b1;
      // a clear only sticks once fresh edges have ended the timeout
      repeat (12) @(negedge mclk);
      rtc_host_model_i.wr(A_CTL, 8'hC0);
      rdchk(A_CTL, 8'hC0);
      rtc_host_model_i.wr(A_CTL, 8'h80);
      osc_run = 1'b0;
      wait_hi(120, 1'b1, n);
      chk32("detector off", 120, n);
      rdchk(A_CTL, 8'h80);
      osc_run = 1'b1;
      rtc_host_model_i.wr(A_LD, 8'h86);
      rtc_host_model_i.poll(A_LD, 6, 1'b1, ok);
      chk8("load ready", 8'h01, {7'h00, ok});
      rdchk(A_LD, 8'hC6);
      chk8("load cap", 8'h06, 8'(osc_ctl.load_cap));
      rtc_host_model_i.wr(A_LD, 8'h33);
      repeat (50) @(negedge mclk);
      rtc_host_model_i.rd(A_LD, d);
      chk8("load cfg", 8'h03, d);
      chk8("load cap", 8'h06, 8'(osc_ctl.load_cap));
      final_report();
   end
endmodule : tb
